// *** logic/amx_register_bank.sv ***
// Function
// - Legacy mixer registers except mic mix are reachable directly at their own location.
// - Filter bits in capture-source and stereo registers are ignored.
// - Extension registers are reached only via the address/data port pair.
// - Address port value indexes the register moved through the data port.
// - Mic mix volume register clears to zero on reset.
// - Override bit plus serial mode selects the override source and volume.
// - Mono override volume drives both left and right input channels.
// - Override in serial mode with bypass bit set bypasses mic preamp.
// - Override source field: 00 line, 01 CD, 10 mic, 11 mixer.
// - Override volume supersedes the command-set input volume.
// - Second DMA reload count is 16 bits in low and high registers.
// - Control two: irq latch 7:6, sign 2, stereo 1, width 0.
`default_nettype none
module amx_register_bank (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] direct_addr,
    input wire logic direct_wr,
    input wire logic [7:0] direct_wdata,
    output logic [7:0] direct_rdata,
    output logic [7:0] io_rdata,
    input wire logic serial_mode_pin,
    input wire logic [1:0] normal_source,
    input wire logic [3:0] cmd_volume_left,
    input wire logic [3:0] cmd_volume_right,
    input wire logic hw_volume_event,
    output amx_pkg::amx_input_type input_path,
    output amx_pkg::amx_dma2_type dma2_cfg,
    output logic hw_volume_irq
);
    logic [7:0] index;
    logic [7:0] regs [amx_pkg::NREG];
    logic [7:0] offs [amx_pkg::NREG];
    logic [7:0] masks [amx_pkg::NREG];
    logic hwv_req;
    logic serial_sync1, serial_sync2;
    logic ext_wr, ext_rd;
    logic soft_reset;
    logic serial_active, override_on;
    logic [7:0] ext_rdata, dir_rdata_c;

    assign offs = '{amx_pkg::REG_VOICE, amx_pkg::REG_MIC_LEGACY, amx_pkg::REG_CAPTURE_SRC,
        amx_pkg::REG_STEREO_SEL, amx_pkg::REG_MIC_MIX, amx_pkg::REG_MAIN_VOL,
        amx_pkg::REG_SYNTH_VOL, amx_pkg::REG_CD_VOL, amx_pkg::REG_LINE_VOL,
        amx_pkg::REG_SER_IN, amx_pkg::REG_SER_OUT, amx_pkg::REG_SER_ANALOG,
        amx_pkg::REG_SER_MISC, amx_pkg::REG_SER_FILTER, amx_pkg::REG_SER_FORMAT,
        amx_pkg::REG_HWV_CTRL, amx_pkg::REG_DMA2_CNT_LO, amx_pkg::REG_DMA2_CNT_HI,
        amx_pkg::REG_DMA2_CTRL1, amx_pkg::REG_DMA2_CTRL2, amx_pkg::REG_CHIP_ID,
        amx_pkg::REG_HWV_CLEAR, amx_pkg::REG_SOFT_RESET};
    // Filter bits get no storage, so writing them cannot matter
    assign masks = '{amx_pkg::MASK_NIBBLE_PAIR, amx_pkg::MASK_MIC_LEGACY,
        amx_pkg::MASK_CAPTURE, amx_pkg::MASK_STEREO, 8'hff, amx_pkg::MASK_NIBBLE_PAIR,
        amx_pkg::MASK_NIBBLE_PAIR, amx_pkg::MASK_NIBBLE_PAIR, amx_pkg::MASK_NIBBLE_PAIR,
        8'hff, 8'hff, amx_pkg::MASK_SER_ANALOG, amx_pkg::MASK_SER_MISC,
        amx_pkg::MASK_SER_FILTER, 8'hff, amx_pkg::MASK_HWV, 8'hff, 8'hff,
        amx_pkg::MASK_CTRL1, amx_pkg::MASK_CTRL2, 8'h00, 8'h00, 8'h00};

    assign ext_wr = io_wr && io_addr == amx_pkg::PORT_MIX_DATA;
    assign ext_rd = io_rd && io_addr == amx_pkg::PORT_MIX_DATA;
    assign soft_reset = (ext_wr && index == amx_pkg::REG_SOFT_RESET) ||
        (direct_wr && direct_addr == amx_pkg::REG_SOFT_RESET);

    // Index latch for the indirect path
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            index <= amx_pkg::ZERO8;
        end else if (io_wr && io_addr == amx_pkg::PORT_MIX_ADDR) begin
            index <= io_wdata;
        end
    end

    // Serial-mode pin crosses in from outside
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_sync1 <= 1'b0;
            serial_sync2 <= 1'b0;
        end else begin
            serial_sync1 <= serial_mode_pin;
            serial_sync2 <= serial_sync1;
        end
    end

    // Storage; direct writes reach the legacy entries, never mic mix
    genvar g;
    generate
        for (g = 0; g < amx_pkg::NREG; g++) begin : g_reg
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    regs[g] <= amx_pkg::ZERO8;
                end else if (soft_reset) begin
                    regs[g] <= amx_pkg::ZERO8;
                end else if (ext_wr && index == offs[g]) begin
                    regs[g] <= io_wdata & masks[g];
                end else if (g < 9 && offs[g] != amx_pkg::REG_MIC_MIX && direct_wr &&
                        direct_addr == offs[g]) begin
                    regs[g] <= direct_wdata & masks[g];
                end
            end
        end
    endgenerate

    // Hardware volume request: set beats clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hwv_req <= 1'b0;
        end else if (hw_volume_event) begin
            hwv_req <= 1'b1;
        end else if (ext_wr && index == amx_pkg::REG_HWV_CLEAR) begin
            hwv_req <= 1'b0;
        end
    end

    always_comb begin
        ext_rdata = amx_pkg::ZERO8;
        dir_rdata_c = amx_pkg::ZERO8;
        for (int i = 0; i < amx_pkg::NREG; i++) begin
            if (index == offs[i]) begin
                ext_rdata = regs[i];
            end
            if (i < 9 && offs[i] != amx_pkg::REG_MIC_MIX && direct_addr == offs[i]) begin
                dir_rdata_c = regs[i];
            end
        end
        if (index == amx_pkg::REG_CHIP_ID) begin
            ext_rdata = amx_pkg::CHIP_ID_VALUE;
        end
        if (index == amx_pkg::REG_HWV_CTRL) begin
            ext_rdata[amx_pkg::HWV_REQ_BIT] = hwv_req;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= amx_pkg::ZERO8;
            direct_rdata <= amx_pkg::ZERO8;
        end else begin
            direct_rdata <= dir_rdata_c;
            if (ext_rd) begin
                io_rdata <= ext_rdata;
            end else if (io_rd && io_addr == amx_pkg::PORT_MIX_ADDR) begin
                io_rdata <= index;
            end
        end
    end

    // Serial mode: pin or forced bit in misc control
    assign serial_active = serial_sync2 || regs[12][amx_pkg::OVR_BIT];
    assign override_on = serial_active && regs[9][amx_pkg::OVR_BIT];

    // Outputs registered to keep the analog controls glitch free
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            input_path <= '0;
        end else if (override_on) begin
            input_path.source <= regs[9][amx_pkg::SRC_HI:amx_pkg::SRC_LO];
            input_path.volume_left <= regs[9][3:0];
            input_path.volume_right <= regs[9][3:0];
            input_path.mic_preamp_bypass <= regs[9][amx_pkg::BYPASS_BIT];
        end else begin
            input_path.source <= normal_source;
            input_path.volume_left <= cmd_volume_left;
            input_path.volume_right <= cmd_volume_right;
            input_path.mic_preamp_bypass <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dma2_cfg <= '0;
            hw_volume_irq <= 1'b0;
        end else begin
            dma2_cfg.reload_count <= {regs[17], regs[16]};
            dma2_cfg.demand <= regs[18][7:6];
            dma2_cfg.auto_init <= regs[18][4];
            dma2_cfg.dma_enable <= regs[18][1];
            dma2_cfg.full_duplex <= regs[18][0];
            dma2_cfg.irq_latch <= regs[19][7:6];
            dma2_cfg.data_signed <= regs[19][2];
            dma2_cfg.stereo <= regs[19][1];
            dma2_cfg.wide16 <= regs[19][0];
            hw_volume_irq <= hwv_req && regs[15][1];
        end
    end

    property p_override_vol;
        @(posedge core_clk) disable iff (!nrst)
        override_on |=> input_path.volume_left == input_path.volume_right;
    endproperty
    a_override_vol: assert property (p_override_vol) else $error("override vol split");

    property p_mic_reset;
        @(posedge core_clk) disable iff (!nrst)
        soft_reset |=> regs[4] == amx_pkg::ZERO8;
    endproperty
    a_mic_reset: assert property (p_mic_reset) else $error("mic mix not cleared");

    property p_filter_ignored;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |-> (regs[2] & ~amx_pkg::MASK_CAPTURE) == amx_pkg::ZERO8 &&
            (regs[3] & ~amx_pkg::MASK_STEREO) == amx_pkg::ZERO8;
    endproperty
    a_filter_ignored: assert property (p_filter_ignored) else $error("filter bit kept");

    property p_no_override;
        @(posedge core_clk) disable iff (!nrst)
        !override_on |=> input_path.source == $past(normal_source) &&
            !input_path.mic_preamp_bypass;
    endproperty
    a_no_override: assert property (p_no_override) else $error("override leaked");

    property p_source;
        @(posedge core_clk) disable iff (!nrst)
        override_on |=> input_path.source == $past(regs[9][5:4]);
    endproperty
    a_source: assert property (p_source) else $error("wrong override source");

    property p_count;
        @(posedge core_clk) disable iff (!nrst)
        ##1 dma2_cfg.reload_count == {$past(regs[17]), $past(regs[16])};
    endproperty
    a_count: assert property (p_count) else $error("reload count mismatch");

    property p_index;
        @(posedge core_clk) disable iff (!nrst)
        io_wr && io_addr == amx_pkg::PORT_MIX_ADDR |=> index == $past(io_wdata);
    endproperty
    a_index: assert property (p_index) else $error("index not latched");

    property p_ctrl1;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |-> (regs[18] & ~amx_pkg::MASK_CTRL1) == amx_pkg::ZERO8;
    endproperty
    a_ctrl1: assert property (p_ctrl1) else $error("reserved control bit set");

    property p_mix_indirect;
        @(posedge core_clk) disable iff (!nrst)
        direct_wr && direct_addr != amx_pkg::REG_SOFT_RESET && !ext_wr |=> $stable(regs[4]);
    endproperty
    a_mix_indirect: assert property (p_mix_indirect) else $error("mic mix direct");

    property p_ext_write;
        @(posedge core_clk) disable iff (!nrst)
        ext_wr && index == amx_pkg::REG_SER_IN && !soft_reset |=> regs[9] == $past(io_wdata);
    endproperty
    a_ext_write: assert property (p_ext_write) else $error("data port write lost");

    property p_ext_read;
        @(posedge core_clk) disable iff (!nrst)
        ext_rd && index == amx_pkg::REG_MIC_MIX |=> io_rdata == $past(regs[4]);
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("data port read wrong");

    property p_addr_read;
        @(posedge core_clk) disable iff (!nrst)
        io_rd && io_addr == amx_pkg::PORT_MIX_ADDR |=> io_rdata == $past(index);
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("index read wrong");

    property p_direct_read;
        @(posedge core_clk) disable iff (!nrst)
        direct_addr == amx_pkg::REG_VOICE |=> direct_rdata == $past(regs[0]);
    endproperty
    a_direct_read: assert property (p_direct_read) else $error("direct read wrong");

    property p_chip_id;
        @(posedge core_clk) disable iff (!nrst)
        ext_rd && index == amx_pkg::REG_CHIP_ID |=> io_rdata == amx_pkg::CHIP_ID_VALUE;
    endproperty
    a_chip_id: assert property (p_chip_id) else $error("identifier wrong");

    property p_ctrl2;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |-> (regs[19] & ~amx_pkg::MASK_CTRL2) == amx_pkg::ZERO8;
    endproperty
    a_ctrl2: assert property (p_ctrl2) else $error("reserved bit in control two");

    property p_bypass;
        @(posedge core_clk) disable iff (!nrst)
        override_on |=> input_path.mic_preamp_bypass == $past(regs[9][amx_pkg::BYPASS_BIT]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("preamp bypass wrong");

    property p_override_level;
        @(posedge core_clk) disable iff (!nrst)
        override_on |=> input_path.volume_left == $past(regs[9][3:0]);
    endproperty
    a_override_level: assert property (p_override_level) else $error("override vol ignored");

    property p_ctrl1_fields;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |=> dma2_cfg.demand == $past(regs[18][7:6]) &&
            dma2_cfg.auto_init == $past(regs[18][4]) &&
            dma2_cfg.dma_enable == $past(regs[18][1]) &&
            dma2_cfg.full_duplex == $past(regs[18][0]);
    endproperty
    a_ctrl1_fields: assert property (p_ctrl1_fields) else $error("control one fields");

    property p_ctrl2_fields;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |=> dma2_cfg.irq_latch == $past(regs[19][7:6]) &&
            dma2_cfg.data_signed == $past(regs[19][2]) &&
            dma2_cfg.stereo == $past(regs[19][1]) &&
            dma2_cfg.wide16 == $past(regs[19][0]);
    endproperty
    a_ctrl2_fields: assert property (p_ctrl2_fields) else $error("control two fields");

    property p_hwv_clear;
        @(posedge core_clk) disable iff (!nrst)
        ext_wr && index == amx_pkg::REG_HWV_CLEAR && !hw_volume_event |=> !hwv_req;
    endproperty
    a_hwv_clear: assert property (p_hwv_clear) else $error("volume request not cleared");
endmodule
`default_nettype wire

// *** include/amx_pkg.sv ***
`default_nettype none
package amx_pkg;
    localparam logic [7:0] REG_SOFT_RESET = 8'h00;
    localparam logic [7:0] REG_VOICE = 8'h04;
    localparam logic [7:0] REG_MIC_LEGACY = 8'h0a;
    localparam logic [7:0] REG_CAPTURE_SRC = 8'h0c;
    localparam logic [7:0] REG_STEREO_SEL = 8'h0e;
    localparam logic [7:0] REG_MIC_MIX = 8'h1a;
    localparam logic [7:0] REG_MAIN_VOL = 8'h22;
    localparam logic [7:0] REG_SYNTH_VOL = 8'h26;
    localparam logic [7:0] REG_CD_VOL = 8'h28;
    localparam logic [7:0] REG_LINE_VOL = 8'h2e;
    localparam logic [7:0] REG_CHIP_ID = 8'h40;
    localparam logic [7:0] REG_SER_IN = 8'h42;
    localparam logic [7:0] REG_SER_OUT = 8'h44;
    localparam logic [7:0] REG_SER_ANALOG = 8'h46;
    localparam logic [7:0] REG_SER_MISC = 8'h48;
    localparam logic [7:0] REG_SER_FILTER = 8'h4c;
    localparam logic [7:0] REG_SER_FORMAT = 8'h4e;
    localparam logic [7:0] REG_HWV_CTRL = 8'h64;
    localparam logic [7:0] REG_HWV_CLEAR = 8'h66;
    localparam logic [7:0] REG_DMA2_CNT_LO = 8'h74;
    localparam logic [7:0] REG_DMA2_CNT_HI = 8'h76;
    localparam logic [7:0] REG_DMA2_CTRL1 = 8'h78;
    localparam logic [7:0] REG_DMA2_CTRL2 = 8'h7a;
    // Port offsets within the I/O window (base+4, base+5)
    localparam logic [3:0] PORT_MIX_ADDR = 4'h4;
    localparam logic [3:0] PORT_MIX_DATA = 4'h5;
    // Arbitrary neutral identification value
    localparam logic [7:0] CHIP_ID_VALUE = 8'h5a;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Writable masks
    localparam logic [7:0] MASK_NIBBLE_PAIR = 8'hee;
    localparam logic [7:0] MASK_MIC_LEGACY = 8'h06;
    localparam logic [7:0] MASK_CAPTURE = 8'h06;
    localparam logic [7:0] MASK_STEREO = 8'h02;
    localparam logic [7:0] MASK_HWV = 8'h43;
    localparam logic [7:0] MASK_CTRL1 = 8'hd3;
    localparam logic [7:0] MASK_CTRL2 = 8'hc7;
    localparam logic [7:0] MASK_SER_ANALOG = 8'hbf;
    localparam logic [7:0] MASK_SER_MISC = 8'hf8;
    localparam logic [7:0] MASK_SER_FILTER = 8'h8f;
    localparam int OVR_BIT = 7;
    localparam int BYPASS_BIT = 6;
    localparam int SRC_HI = 5;
    localparam int SRC_LO = 4;
    localparam int HWV_REQ_BIT = 4;
    localparam int NREG = 23;

    typedef struct packed {
        logic [1:0] source;
        logic [3:0] volume_left;
        logic [3:0] volume_right;
        logic mic_preamp_bypass;
    } amx_input_type;

    typedef struct packed {
        logic [1:0] demand;
        logic auto_init;
        logic dma_enable;
        logic full_duplex;
        logic [1:0] irq_latch;
        logic data_signed;
        logic stereo;
        logic wide16;
        logic [15:0] reload_count;
    } amx_dma2_type;
endpackage
`default_nettype wire

// *** bench/amx_register_bank_bench.sv ***
`default_nettype none
module amx_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] io_addr = 4'h0;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] direct_addr = 8'h00;
    logic direct_wr = 1'b0;
    logic [7:0] direct_wdata = 8'h00;
    logic [7:0] direct_rdata;
    logic [7:0] io_rdata;
    logic serial_mode_pin = 1'b0;
    logic [1:0] normal_source = 2'b01;
    logic [3:0] cmd_volume_left = 4'h3;
    logic [3:0] cmd_volume_right = 4'h5;
    logic hw_volume_event = 1'b0;
    amx_pkg::amx_input_type input_path;
    amx_pkg::amx_dma2_type dma2_cfg;
    logic hw_volume_irq;
    amx_pkg::amx_input_type exp_path;
    logic [7:0] v;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    amx_register_bank u_amx_register_bank (
        .core_clk, .nrst, .io_addr, .io_wr, .io_rd, .io_wdata, .direct_addr, .direct_wr,
        .direct_wdata, .direct_rdata, .io_rdata, .serial_mode_pin, .normal_source,
        .cmd_volume_left, .cmd_volume_right, .hw_volume_event, .input_path, .dma2_cfg,
        .hw_volume_irq
    );

    always #10 core_clk = ~core_clk;

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 200 cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Trailing edge keeps strobes from being raised again in the same step
    task automatic io_write(input logic [3:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge core_clk);
        io_wr = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic io_read(input logic [3:0] a);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge core_clk);
        io_rd = 1'b0;
        @(negedge core_clk);
        v = io_rdata;
    endtask

    task automatic ext_write(input logic [7:0] idx, input logic [7:0] d);
        io_write(amx_pkg::PORT_MIX_ADDR, idx);
        io_write(amx_pkg::PORT_MIX_DATA, d);
    endtask

    task automatic ext_read(input logic [7:0] idx, input string what, input logic [7:0] e);
        io_write(amx_pkg::PORT_MIX_ADDR, idx);
        io_read(amx_pkg::PORT_MIX_DATA);
        check(what, {8'h00, e}, {8'h00, v});
    endtask

    task automatic dir_write(input logic [7:0] a, input logic [7:0] d);
        direct_addr = a;
        direct_wdata = d;
        direct_wr = 1'b1;
        @(negedge core_clk);
        direct_wr = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic dir_read(input logic [7:0] a, input string what, input logic [7:0] e);
        direct_addr = a;
        repeat (2) @(negedge core_clk);
        check(what, {8'h00, e}, {8'h00, direct_rdata});
    endtask

    task automatic chk_path(input logic [1:0] s, input logic [3:0] l, input logic [3:0] r,
                            input logic b);
        exp_path.source = s;
        exp_path.volume_left = l;
        exp_path.volume_right = r;
        exp_path.mic_preamp_bypass = b;
        repeat (4) @(negedge core_clk);
        check("input_path", {5'h00, exp_path}, {5'h00, input_path});
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        ext_read(amx_pkg::REG_MIC_MIX, "mic_mix_volume", 8'h00);
        ext_write(amx_pkg::REG_CHIP_ID, 8'hff);
        ext_read(amx_pkg::REG_CHIP_ID, "chip_identifier", amx_pkg::CHIP_ID_VALUE);
        io_read(amx_pkg::PORT_MIX_ADDR);
        check("index", {8'h00, amx_pkg::REG_CHIP_ID}, {8'h00, v});
        $display("test reset_and_index done");
        dir_write(amx_pkg::REG_VOICE, 8'hff);
        dir_read(amx_pkg::REG_VOICE, "voice_volume", 8'hee);
        dir_write(amx_pkg::REG_CAPTURE_SRC, 8'hff);
        dir_read(amx_pkg::REG_CAPTURE_SRC, "capture_source_select", 8'h06);
        dir_write(amx_pkg::REG_STEREO_SEL, 8'hff);
        dir_read(amx_pkg::REG_STEREO_SEL, "output_stereo_select", 8'h02);
        dir_write(amx_pkg::REG_SER_IN, 8'hff);
        dir_read(amx_pkg::REG_SER_IN, "direct_extension", 8'h00);
        ext_read(amx_pkg::REG_SER_IN, "serial_input_override", 8'h00);
        ext_write(amx_pkg::REG_MIC_MIX, 8'h21);
        dir_write(amx_pkg::REG_MIC_MIX, 8'hff);
        dir_read(amx_pkg::REG_MIC_MIX, "direct_mic_mix", 8'h00);
        ext_read(amx_pkg::REG_MIC_MIX, "mic_mix_indirect", 8'h21);
        ext_read(8'h50, "unmapped", 8'h00);
        ext_write(amx_pkg::REG_MIC_MIX, 8'h5a);
        ext_read(amx_pkg::REG_MIC_MIX, "mic_mix_volume", 8'h5a);
        dir_write(amx_pkg::REG_SOFT_RESET, 8'h00);
        ext_read(amx_pkg::REG_MIC_MIX, "mic_mix_after_reset", 8'h00);
        dir_read(amx_pkg::REG_VOICE, "voice_after_reset", 8'h00);
        $display("test direct_and_reset done");
        ext_write(amx_pkg::REG_DMA2_CNT_LO, 8'h34);
        ext_write(amx_pkg::REG_DMA2_CNT_HI, 8'h12);
        ext_read(amx_pkg::REG_DMA2_CNT_HI, "dma2_count_high", 8'h12);
        check("reload_count", 16'h1234, dma2_cfg.reload_count);
        ext_write(amx_pkg::REG_DMA2_CTRL1, 8'h52);
        ext_read(amx_pkg::REG_DMA2_CTRL1, "dma2_control_first", 8'h52);
        check("ctrl1_fields", 16'h000e, {11'h000, dma2_cfg.demand, dma2_cfg.auto_init,
              dma2_cfg.dma_enable, dma2_cfg.full_duplex});
        ext_write(amx_pkg::REG_DMA2_CTRL2, 8'hff);
        ext_read(amx_pkg::REG_DMA2_CTRL2, "dma2_control_second", 8'hc7);
        check("ctrl2_fields", 16'h001f, {11'h000, dma2_cfg.irq_latch, dma2_cfg.data_signed,
              dma2_cfg.stereo, dma2_cfg.wide16});
        $display("test dma2 done");
        // Override set but serial mode off: normal settings must stay
        ext_write(amx_pkg::REG_SER_IN, 8'hea);
        chk_path(2'b01, 4'h3, 4'h5, 1'b0);
        serial_mode_pin = 1'b1;
        for (int s = 0; s < 4; s++) begin
            ext_write(amx_pkg::REG_SER_IN, {2'b11, s[1:0], 4'h9});
            chk_path(s[1:0], 4'h9, 4'h9, 1'b1);
        end
        ext_write(amx_pkg::REG_SER_IN, 8'h7a);
        chk_path(2'b01, 4'h3, 4'h5, 1'b0);
        ext_write(amx_pkg::REG_SER_IN, 8'h9c);
        chk_path(2'b01, 4'hc, 4'hc, 1'b0);
        serial_mode_pin = 1'b0;
        ext_write(amx_pkg::REG_SER_MISC, 8'h80);
        chk_path(2'b01, 4'hc, 4'hc, 1'b0);
        $display("test serial_override done");
        hw_volume_event = 1'b1;
        @(negedge core_clk);
        hw_volume_event = 1'b0;
        ext_write(amx_pkg::REG_HWV_CTRL, 8'hff);
        ext_read(amx_pkg::REG_HWV_CTRL, "hw_volume_control", 8'h53);
        check("hw_volume_irq", 16'h0001, {15'h0000, hw_volume_irq});
        ext_write(amx_pkg::REG_HWV_CLEAR, 8'h00);
        repeat (2) @(negedge core_clk);
        check("hw_volume_irq_cleared", 16'h0000, {15'h0000, hw_volume_irq});
        // Event and clear on one edge: the event must win
        io_write(amx_pkg::PORT_MIX_ADDR, amx_pkg::REG_HWV_CLEAR);
        hw_volume_event = 1'b1;
        io_addr = amx_pkg::PORT_MIX_DATA;
        io_wr = 1'b1;
        @(negedge core_clk);
        hw_volume_event = 1'b0;
        io_wr = 1'b0;
        repeat (2) @(negedge core_clk);
        check("hw_volume_irq_set_wins", 16'h0001, {15'h0000, hw_volume_irq});
        $display("test hw_volume done");
        end_of_test();
    end
endmodule
`default_nettype wire
